// *** common/sbsw_defs.svh ***
// Constants for the send-byte switch controller
`ifndef SBSW_DEFS_SVH
`define SBSW_DEFS_SVH
`define SBSW_ADDR_HI5      5'h16
`define SBSW_ADDR_LO_LOW   2'h0
`define SBSW_ADDR_LO_MID   2'h1
`define SBSW_ADDR_LO_HIGH  2'h2
`define SBSW_SEL_LOW       2'h0
`define SBSW_SEL_MID       2'h1
`define SBSW_SEL_HIGH      2'h2
`define SBSW_BIT_CNT_W     4
`define SBSW_BITS_PER_BYTE 4'h8
`define SBSW_SW_RESET      2'h0
`endif

// *** common/sbsw_pkg.sv ***
// Types for the send-byte switch controller
package sbsw_pkg;
    typedef enum logic [4:0] {
        SBSW_IDLE = 5'b00001,
        SBSW_ADDR = 5'b00010,
        SBSW_AACK = 5'b00100,
        SBSW_CMD  = 5'b01000,
        SBSW_CACK = 5'b10000
    } sbsw_state_e;
    typedef struct packed {
        logic scl;
        logic sda;
    } sbsw_bus_s;
endpackage : sbsw_pkg

// *** src/sbsw_ctrl.sv ***
// SMBus send-byte slave driving two power switch enables
`timescale 1ns/1ps
`default_nettype none
`include "sbsw_defs.svh"
module sbsw_ctrl
    import sbsw_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // Bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oen,
    // Three-level address select, already resolved to low/mid/high code
    input  wire logic [1:0] i_address_select_pin,
    // Switch enables
    output logic            o_switch0_output,
    output logic            o_switch1_output
);
    // ****************************************************************
    // Synchronisers and edge detection
    // ****************************************************************
    sbsw_bus_s   meta_reg;
    sbsw_bus_s   sync_reg;
    sbsw_bus_s   last_reg;
    logic [1:0]  sel_meta_reg;
    logic [1:0]  sel_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg     <= '{scl: 1'b1, sda: 1'b1};
            sync_reg     <= '{scl: 1'b1, sda: 1'b1};
            last_reg     <= '{scl: 1'b1, sda: 1'b1};
            sel_meta_reg <= `SBSW_SEL_LOW;
            sel_reg      <= `SBSW_SEL_LOW;
        end
        else
        begin
            meta_reg     <= '{scl: i_scl, sda: i_sda};
            sync_reg     <= meta_reg;
            last_reg     <= sync_reg;
            sel_meta_reg <= i_address_select_pin;
            sel_reg      <= sel_meta_reg;
        end
    end
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = sync_reg.scl & ~last_reg.scl;
    assign scl_fall  = ~sync_reg.scl & last_reg.scl;
    assign start_det = sync_reg.scl & last_reg.scl & last_reg.sda & ~sync_reg.sda;
    assign stop_det  = sync_reg.scl & last_reg.scl & ~last_reg.sda & sync_reg.sda;

    // ****************************************************************
    // Own address
    // ****************************************************************
    logic [6:0] own_addr;
    always_comb
    begin
        case (sel_reg)
            `SBSW_SEL_MID:  own_addr = {`SBSW_ADDR_HI5, `SBSW_ADDR_LO_MID};
            `SBSW_SEL_HIGH: own_addr = {`SBSW_ADDR_HI5, `SBSW_ADDR_LO_HIGH};
            default:        own_addr = {`SBSW_ADDR_HI5, `SBSW_ADDR_LO_LOW};
        endcase
    end

    // ****************************************************************
    // Transfer state machine
    // ****************************************************************
    sbsw_state_e                 state_reg;
    logic [7:0]                  shift_reg;
    logic [`SBSW_BIT_CNT_W-1:0]  cnt_reg;
    logic                        ack_done_reg;
    logic                        cmd_valid_reg;
    logic [1:0]                  hold_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg     <= SBSW_IDLE;
            shift_reg     <= 8'h00;
            cnt_reg       <= '0;
            ack_done_reg  <= 1'b0;
            cmd_valid_reg <= 1'b0;
            hold_reg      <= `SBSW_SW_RESET;
        end
        else if (start_det)
        begin
            state_reg     <= SBSW_ADDR;
            cnt_reg       <= '0;
            cmd_valid_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            // Stop consumes any pending command, so a stray second Stop cannot replay it
            state_reg     <= SBSW_IDLE;
            cmd_valid_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                SBSW_ADDR, SBSW_CMD:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sync_reg.sda};
                        cnt_reg   <= cnt_reg + 1'b1;
                    end
                    else if (scl_fall && cnt_reg == `SBSW_BITS_PER_BYTE)
                    begin
                        cnt_reg      <= '0;
                        ack_done_reg <= 1'b0;
                        if (state_reg == SBSW_CMD)
                            state_reg <= SBSW_CACK;
                        else if (shift_reg == {own_addr, 1'b0})
                            state_reg <= SBSW_AACK;
                        else
                            state_reg <= SBSW_IDLE;
                    end
                end
                SBSW_AACK, SBSW_CACK:
                begin
                    if (scl_rise)
                        ack_done_reg <= 1'b1;
                    else if (scl_fall && ack_done_reg)
                    begin
                        if (state_reg == SBSW_AACK)
                            state_reg <= SBSW_CMD;
                        else
                        begin
                            state_reg     <= SBSW_IDLE;
                            hold_reg      <= shift_reg[1:0];
                            cmd_valid_reg <= 1'b1;
                        end
                    end
                end
                SBSW_IDLE: ;
                default: state_reg <= SBSW_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Open-drain acknowledge
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_sda_oen <= 1'b1;
        else
            o_sda_oen <= ~((state_reg == SBSW_AACK || state_reg == SBSW_CACK)
                           && !start_det && !stop_det);
    end
    assign o_sda_out = 1'b0;

    // ****************************************************************
    // Output enables, updated at Stop only
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_switch0_output <= 1'b0;
            o_switch1_output <= 1'b0;
        end
        else if (stop_det && cmd_valid_reg)
        begin
            o_switch0_output <= hold_reg[0];
            o_switch1_output <= hold_reg[1];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    AST_SW_ONLY_AT_STOP: assert property (!stop_det |=> $stable({o_switch1_output, o_switch0_output}))
        else $error("switch output changed without stop");
    AST_STOP_LOADS: assert property (stop_det && cmd_valid_reg |=> o_switch0_output == $past(hold_reg[0])
        && o_switch1_output == $past(hold_reg[1]))
        else $error("stop did not copy holding latch");
    AST_START_ADDR: assert property (start_det |=> state_reg == SBSW_ADDR && cnt_reg == '0)
        else $error("start did not arm address phase");
    AST_IDLE_RELEASE: assert property (state_reg == SBSW_IDLE |=> o_sda_oen)
        else $error("data driven while idle");
    AST_START_DISCARD: assert property (start_det |=> !cmd_valid_reg)
        else $error("start kept pending command");
    AST_READ_IGNORED: assert property (state_reg == SBSW_ADDR && scl_fall && cnt_reg == `SBSW_BITS_PER_BYTE
        && shift_reg[0] && !start_det && !stop_det |=> state_reg == SBSW_IDLE)
        else $error("read transfer not ignored");
    AST_ADDR_MATCH: assert property (state_reg == SBSW_AACK |-> shift_reg[7:3] == `SBSW_ADDR_HI5
        && shift_reg[2:1] != 2'b11 && !shift_reg[0])
        else $error("address high bits wrong");
    AST_SYNC_EDGE: assert property (scl_rise |-> $past(meta_reg.scl) && !$past(meta_reg.scl, 2))
        else $error("clock edge not from synchronised samples");
    COV_CMD: cover property (state_reg == SBSW_CACK ##[1:400] cmd_valid_reg);
    COV_ON: cover property ($rose(o_switch0_output) && $rose(o_switch1_output));
    COV_ABORT: cover property (state_reg == SBSW_CMD && cnt_reg != '0 && start_det);
    COV_STOP_ABORT: cover property (state_reg == SBSW_CMD && cnt_reg != '0 && stop_det);
endmodule : sbsw_ctrl
`default_nettype wire

// *** test/sbsw_host.sv ***
// Behavioural bus host that drives clock and data for the switch controller
`timescale 1ns/1ps
`default_nettype none
module sbsw_host
(
    // Clock
    input  wire logic i_clk,
    // Bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_rel
);
    // Released data goes to the pull-up level; any zero on the wire wins (lost arbitration)
    initial
    begin
        o_scl     = 1'b1;
        o_sda_rel = 1'b1;
    end
    // Quarter bit of two clocks, so one bit lasts 200 ns
    task automatic wait_q;
        repeat (2) @(posedge i_clk);
        #1;
    endtask : wait_q
    task automatic start;
        o_sda_rel = 1'b1;
        wait_q;
        o_scl = 1'b1;
        wait_q;
        o_sda_rel = 1'b0;
        wait_q;
        o_scl = 1'b0;
        wait_q;
    endtask : start
    task automatic stop;
        o_sda_rel = 1'b0;
        wait_q;
        o_scl = 1'b1;
        wait_q;
        o_sda_rel = 1'b1;
        wait_q;
    endtask : stop
    // Data changes in mid-low and is sampled at the end of the high phase
    task automatic put_bit(input logic b, output logic seen);
        o_sda_rel = b;
        wait_q;
        o_scl = 1'b1;
        wait_q;
        wait_q;
        seen = i_sda;
        o_scl = 1'b0;
        wait_q;
    endtask : put_bit
    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, ack_n);
    endtask : send_byte
endmodule : sbsw_host
`default_nettype wire

// *** test/smbus_send_byte_switch_ctrl_bench.sv ***
// Self-checking bench for the send-byte switch controller
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module smbus_send_byte_switch_ctrl_bench;
    import sbsw_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rstn = 1'b0;
    logic [1:0] sel = 2'h0;
    logic       scl;
    logic       rel;
    logic       sda_out;
    logic       sda_oen;
    logic       sw0;
    logic       sw1;
    logic [1:0] sw_now = 2'h0;
    int         errors = 0;
    int         compares = 0;
    int         cycles = 0;
    wire        sda = rel & (sda_oen | sda_out);
    always #12.5 i_clk = ~i_clk;
    sbsw_ctrl dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oen(sda_oen), .i_address_select_pin(sel), .o_switch0_output(sw0), .o_switch1_output(sw1));
    sbsw_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(rel));
    task automatic complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run;
        end
    end
    // One transfer: address byte, command byte, then Stop
    task automatic shot(input logic [1:0] s, input logic [7:0] a, input logic [7:0] c, input logic nak,
                        input logic [1:0] esw);
        logic k;
        sel = s;
        host.start;
        host.send_byte(a, k);
        `CHECK("address ack", nak, k)
        host.send_byte(c, k);
        `CHECK("command ack", nak, k)
        `CHECK("switches before stop", sw_now, {sw1, sw0})
        `CHECK("data value", 1'b0, sda_out)
        host.stop;
        host.wait_q;
        host.wait_q;
        `CHECK("switches", esw, {sw1, sw0})
        sw_now = esw;
    endtask : shot
    task automatic test_commands;
        shot(2'h3, 8'hB0, 8'h02, 1'b0, 2'b10);
        shot(2'h0, 8'hB0, 8'hFD, 1'b0, 2'b01);
        shot(2'h1, 8'hB2, 8'h02, 1'b0, 2'b10);
        shot(2'h2, 8'hB4, 8'hAB, 1'b0, 2'b11);
        shot(2'h0, 8'hB0, 8'h00, 1'b0, 2'b00);
        shot(2'h2, 8'hB4, 8'h03, 1'b0, 2'b11);
    endtask : test_commands
    task automatic test_refused;
        shot(2'h0, 8'hB2, 8'h00, 1'b1, 2'b11);
        shot(2'h0, 8'hB1, 8'h00, 1'b1, 2'b11);
    endtask : test_refused
    task automatic test_abort;
        logic k;
        sel = 2'h1;
        host.start;
        host.send_byte(8'hB2, k);
        for (int i = 0; i < 3; i++) host.put_bit(1'b0, k);
        host.stop;
        host.wait_q;
        host.wait_q;
        `CHECK("switches after aborted byte", 2'b11, {sw1, sw0})
        host.start;
        host.send_byte(8'hB2, k);
        host.send_byte(8'h00, k);
        host.start;
        host.stop;
        host.wait_q;
        host.wait_q;
        `CHECK("switches after repeated start", 2'b11, {sw1, sw0})
    endtask : test_abort
    task automatic test_reset;
        @(posedge i_clk);
        #1 i_rstn = 1'b0;
        repeat (2) @(posedge i_clk);
        `CHECK("switches in reset", 2'b00, {sw1, sw0})
        `CHECK("data enable in reset", 1'b1, sda_oen)
        #1 i_rstn = 1'b1;
        repeat (3) @(posedge i_clk);
        sw_now = 2'b00;
    endtask : test_reset
    initial
    begin
        repeat (5) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        repeat (3) @(posedge i_clk);
        `CHECK("switches after reset", 2'b00, {sw1, sw0})
        test_commands;
        test_refused;
        test_abort;
        test_reset;
        shot(2'h1, 8'hB2, 8'h01, 1'b0, 2'b01);
        complete_run;
    end
endmodule : smbus_send_byte_switch_ctrl_bench
`default_nettype wire
